/* File: pid_regs.vh */
// register offsets, field positions, reset values and timing counts
// for the process regulator; included by the regulator top only
`ifndef PID_REGS_VH
`define PID_REGS_VH

// register byte offsets on the apb bus
`define PID_CTRL_OFF 8'h00
`define PID_MODE_OFF 8'h04
`define PID_KEYPAD_OFF 8'h08
`define PID_KP_OFF 8'h0C
`define PID_TI_OFF 8'h10
`define PID_TD_OFF 8'h14
`define PID_TS_OFF 8'h18
`define PID_DEADBAND_OFF 8'h1C
`define PID_UPPER_OFF 8'h20
`define PID_LOWER_OFF 8'h24
`define PID_STATUS_OFF 8'h28

// control register fields
`define PID_CTRL_SRC_LSB 0
`define PID_CTRL_FB_LSB 4
`define PID_CTRL_POL_BIT 8
// mode register fields
`define PID_MODE_PRI_LSB 0
`define PID_MODE_SEC_LSB 4
`define PID_MODE_VOLT_LSB 8

// selection codes that put the drive into process regulation
`define PID_FREQ_CMD_CODE 4'h7
`define PID_VOLT_CMD_CODE 4'h6

// reset values; percent in 0.1 % steps, gain in 0.01, Ti and Td in 10 ms, Ts in 1 ms
`define PID_KEYPAD_RST 16'h0000
`define PID_KP_RST 16'h0064
`define PID_TI_RST 16'h0064
`define PID_TD_RST 16'h0000
`define PID_TS_RST 16'h0064
`define PID_DEADBAND_RST 16'h0000
`define PID_UPPER_RST 16'h03E8
`define PID_LOWER_RST 16'hFE0C

// setting ranges
`define PID_FULL_SCALE 16'h03E8
`define PID_KP_MAX 16'h2710
`define PID_TI_MAX 16'h1388
`define PID_TD_MAX 16'h03E8
`define PID_TS_MAX 16'h03E8
`define PID_KP_UNIT 24'h002710
`define PID_TIME_UNIT_MS 10
// the same 10 ms step, sized for the 24-bit divisor
`define PID_TI_SCALE 24'h00000A

// timing: sampling period counts in 1 ms steps of the 10 MHz clock
`define PID_CLK_MHZ 10
`define PID_MS_TICK_US 1000
`define PID_MS_CYCLES (`PID_CLK_MHZ * `PID_MS_TICK_US)

`endif

/* File: pid_divider.v */
// sequential signed-by-unsigned restoring divider, one bit per clock
// assumes a nonzero divisor and start only while busy is low
`timescale 1ns/1ps
module pid_divider #(
    parameter DW = 40,
    parameter VW = 24
) (
    input wire clk,
    input wire rst_n,
    input wire start,
    input wire signed [DW-1:0] dividend,
    input wire [VW-1:0] divisor,
    output reg busy,
    output reg done,
    output reg signed [DW-1:0] quotient
);
    reg [DW-1:0] q_q;
    reg [VW:0] rem_q;
    reg [VW-1:0] dvs_q;
    reg neg_q;
    reg [6:0] cnt_q;
    reg [VW:0] trial;
    reg fits;
    reg [DW-1:0] q_next;

    // one restoring step on the running remainder
    always @*
    begin
        trial = {rem_q[VW-1:0], q_q[DW-1]};
        fits = (trial >= {1'b0, dvs_q});
        q_next = {q_q[DW-2:0], fits};
    end

    // magnitude is divided, sign is restored at the end (truncates to 0)
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q_q <= {DW{1'b0}};
            rem_q <= {(VW+1){1'b0}};
            dvs_q <= {VW{1'b0}};
            neg_q <= 1'b0;
            cnt_q <= 7'h00;
            busy <= 1'b0;
            done <= 1'b0;
            quotient <= {DW{1'b0}};
        end
        else
        begin
            done <= 1'b0;
            if (start && !busy)
            begin
                neg_q <= dividend[DW-1];
                q_q <= dividend[DW-1] ? -dividend : dividend;
                rem_q <= {(VW+1){1'b0}};
                dvs_q <= divisor;
                cnt_q <= DW[6:0];
                busy <= 1'b1;
            end
            else if (busy)
            begin
                rem_q <= fits ? trial - {1'b0, dvs_q} : trial;
                q_q <= q_next;
                cnt_q <= cnt_q - 7'h01;
                if (cnt_q == 7'h01)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    quotient <= neg_q ? -q_next : q_next;
                end
            end
        end
    end
endmodule // pid_divider

/* File: pid_regulator.v */
// process regulator: setpoint and feedback selection, sampled pid,
// deadband, output clamping, apb register file
// assumes all inputs synchronous to pclk; channel values in 0.1 % steps
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "pid_regs.vh"

// Function
// - regulate when freq code 7 or voltage 6
// - setpoint code picks keypad, inputs or buses
// - setpoint and feedback are relative percentages
// - keypad setpoint -100..100 %, default zero
// - feedback code picks inputs or buses, default 0
// - polarity 0 lowers output when feedback high
// - polarity 1 raises output when feedback high
// - gain 0..100, 100 gives full-scale per 100 %
// - integral reaches full scale after integral time
// - derivative full scale per 100 % in time
// - one update per sampling period 1..1000 ms
// - deviation limit held, default zero
// - inside deviation limit output stays unchanged
// - output clamped between upper and lower limits
module pid_regulator #(
    parameter MS_CYCLES = `PID_MS_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire signed [15:0] analog_input_one,
    input wire signed [15:0] analog_input_two,
    input wire signed [15:0] analog_input_three,
    input wire signed [15:0] high_speed_pulse_input,
    input wire signed [15:0] multi_step_speed_value,
    input wire signed [15:0] modbus_value,
    input wire signed [15:0] fieldbus_value,
    input wire signed [15:0] ethernet_value,
    output wire pid_active,
    output wire ref_is_voltage,
    output reg signed [15:0] reference_out,
    output reg reference_strobe
);
    localparam S_IDLE = 5'b00001;
    localparam S_PROP = 5'b00010;
    localparam S_INTG = 5'b00100;
    localparam S_DERV = 5'b01000;
    localparam S_SUM = 5'b10000;

    reg [3:0] setpoint_source_select;
    reg [2:0] feedback_source_select;
    reg output_polarity_select;
    reg [3:0] primary_freq_command_select;
    reg [3:0] secondary_freq_command_select;
    reg [3:0] voltage_channel_select;
    reg signed [15:0] keypad_setpoint_value;
    reg [15:0] proportional_gain_setting;
    reg [15:0] integral_time_setting;
    reg [15:0] derivative_time_setting;
    reg [15:0] sample_period_setting;
    reg [15:0] error_deadband_limit;
    reg signed [15:0] output_upper_limit;
    reg signed [15:0] output_lower_limit;

    reg [4:0] state_q;
    reg [13:0] ms_cnt_q;
    reg [9:0] period_cnt_q;
    reg signed [12:0] err_q;
    reg signed [12:0] fb_prev_q;
    reg signed [12:0] dfb_q;
    reg signed [39:0] acc_q;
    reg signed [39:0] p_term_q;
    reg signed [39:0] i_term_q;
    reg in_band_q;
    reg div_start_q;
    reg signed [39:0] div_num_q;
    reg [23:0] div_den_q;
    wire div_busy;
    wire div_done;
    wire signed [39:0] div_quot;

    // clip a signed value into [lo, hi]
    function signed [15:0] clip;
        input signed [41:0] v;
        input signed [15:0] lo;
        input signed [15:0] hi;
        begin
            if (v > hi)
                clip = hi;
            else if (v < lo)
                clip = lo;
            else
                clip = v[15:0];
        end
    endfunction

    // write range limiter for unsigned settings
    function [15:0] umax;
        input [31:0] v;
        input [15:0] hi;
        begin
            umax = (v[31:16] != 16'h0000 || v[15:0] > hi) ? hi : v[15:0];
        end
    endfunction

    wire signed [15:0] full_pos = `PID_FULL_SCALE;
    wire signed [15:0] full_neg = -`PID_FULL_SCALE;

    // process mode decode
    assign pid_active =
        (primary_freq_command_select == `PID_FREQ_CMD_CODE) ||
        (secondary_freq_command_select == `PID_FREQ_CMD_CODE) ||
        (voltage_channel_select == `PID_VOLT_CMD_CODE);
    assign ref_is_voltage = (voltage_channel_select == `PID_VOLT_CMD_CODE);

    // setpoint channel mux; reserved codes give a zero setpoint
    reg signed [15:0] sp_raw;
    always @*
    begin
        case (setpoint_source_select)
            4'h0: sp_raw = keypad_setpoint_value;
            4'h1: sp_raw = analog_input_one;
            4'h2: sp_raw = analog_input_two;
            4'h3: sp_raw = analog_input_three;
            4'h4: sp_raw = high_speed_pulse_input;
            4'h5: sp_raw = multi_step_speed_value;
            4'h6: sp_raw = modbus_value;
            4'h7: sp_raw = fieldbus_value;
            4'h8: sp_raw = ethernet_value;
            default: sp_raw = 16'h0000;
        endcase
    end

    // feedback channel mux; code 7 is reserved and reads zero
    reg signed [15:0] fb_raw;
    always @*
    begin
        case (feedback_source_select)
            3'h0: fb_raw = analog_input_one;
            3'h1: fb_raw = analog_input_two;
            3'h2: fb_raw = analog_input_three;
            3'h3: fb_raw = high_speed_pulse_input;
            3'h4: fb_raw = modbus_value;
            3'h5: fb_raw = fieldbus_value;
            3'h6: fb_raw = ethernet_value;
            default: fb_raw = 16'h0000;
        endcase
    end

    // relative arithmetic: 1000 counts is 100 % of the controlled system
    wire signed [15:0] sp_rel = clip({{26{sp_raw[15]}}, sp_raw},
        full_neg, full_pos);
    wire signed [15:0] fb_rel = clip({{26{fb_raw[15]}}, fb_raw},
        full_neg, full_pos);
    wire signed [12:0] err_raw = sp_rel[12:0] - fb_rel[12:0];
    // polarity 1 flips the sign so rising feedback raises the output
    wire signed [12:0] err_now =
        output_polarity_select ? -err_raw : err_raw;
    wire [12:0] err_mag = err_now[12] ? -err_now : err_now;
    wire in_band = ({3'b000, err_mag} <= error_deadband_limit);
    wire signed [12:0] dfb_now = fb_prev_q - fb_rel[12:0];

    // millisecond prescaler and sampling period counter
    wire ms_tick = (ms_cnt_q == MS_CYCLES - 1);
    wire sample_tick = ms_tick &&
        ({6'h00, period_cnt_q} >= sample_period_setting - 16'h0001);
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ms_cnt_q <= 14'h0000;
            period_cnt_q <= 10'h000;
        end
        else if (!pid_active)
        begin
            ms_cnt_q <= 14'h0000;
            period_cnt_q <= 10'h000;
        end
        else
        begin
            ms_cnt_q <= ms_tick ? 14'h0000 : ms_cnt_q + 14'h0001;
            if (sample_tick)
                period_cnt_q <= 10'h000;
            else if (ms_tick)
                period_cnt_q <= period_cnt_q + 10'h001;
        end
    end

    // integral grows by e*Ts; its term is that sum over ten times Ti
    wire signed [39:0] acc_step = err_now * $signed({1'b0,
        sample_period_setting[9:0]});
    wire signed [39:0] acc_sum = acc_q + acc_step;
    // bound the sum so the integral term alone stays within 200 %
    wire signed [39:0] acc_lim = $signed({16'h0000, 24'h0007D0}) *
        $signed({24'h000000, integral_time_setting}) *
        `PID_TIME_UNIT_MS;

    // one update per sample: P, then I, then D on the shared divider
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= S_IDLE;
            err_q <= 13'h0000;
            fb_prev_q <= 13'h0000;
            dfb_q <= 13'h0000;
            acc_q <= 40'h0000000000;
            p_term_q <= 40'h0000000000;
            i_term_q <= 40'h0000000000;
            in_band_q <= 1'b0;
            div_start_q <= 1'b0;
            div_num_q <= 40'h0000000000;
            div_den_q <= 24'h000001;
            reference_out <= 16'h0000;
            reference_strobe <= 1'b0;
        end
        else
        begin
            div_start_q <= 1'b0;
            reference_strobe <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (sample_tick)
                    begin
                        fb_prev_q <= fb_rel[12:0];
                        dfb_q <= output_polarity_select ? -dfb_now : dfb_now;
                        err_q <= err_now;
                        in_band_q <= in_band;
                        if (!in_band)
                        begin
                            if (acc_sum > acc_lim)
                                acc_q <= acc_lim;
                            else if (acc_sum < -acc_lim)
                                acc_q <= -acc_lim;
                            else
                                acc_q <= acc_sum;
                            // full scale per 100 % error at gain 100.00
                            div_num_q <= err_now *
                                $signed({1'b0, proportional_gain_setting});
                            div_den_q <= `PID_KP_UNIT;
                            div_start_q <= 1'b1;
                            state_q <= S_PROP;
                        end
                    end
                end
                S_PROP:
                begin
                    if (div_done)
                    begin
                        p_term_q <= div_quot;
                        // integral time zero turns the integral off
                        div_num_q <= (integral_time_setting == 16'h0000) ?
                            40'h0000000000 : acc_q;
                        div_den_q <= (integral_time_setting == 16'h0000) ?
                            24'h000001 : {8'h00, integral_time_setting} *
                            `PID_TI_SCALE;
                        div_start_q <= 1'b1;
                        state_q <= S_INTG;
                    end
                end
                S_INTG:
                begin
                    if (div_done)
                    begin
                        i_term_q <= div_quot;
                        // change of feedback times Td over Ts; Td 0 is off
                        div_num_q <= dfb_q * $signed({1'b0,
                            derivative_time_setting}) *
                            `PID_TIME_UNIT_MS;
                        div_den_q <= {8'h00, sample_period_setting};
                        div_start_q <= 1'b1;
                        state_q <= S_DERV;
                    end
                end
                S_DERV:
                begin
                    if (div_done)
                    begin
                        reference_out <= clip(p_term_q + i_term_q + div_quot,
                            output_lower_limit,
                            output_upper_limit);
                        reference_strobe <= 1'b1;
                        state_q <= S_SUM;
                    end
                end
                S_SUM:
                    state_q <= S_IDLE;
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    pid_divider #(
        .DW(40),
        .VW(24)
    ) u_div (
        .clk(pclk),
        .rst_n(presetn),
        .start(div_start_q),
        .dividend(div_num_q),
        .divisor(div_den_q),
        .busy(div_busy),
        .done(div_done),
        .quotient(div_quot)
    );

    // zero-wait apb slave; read data is latched in the setup phase
    assign pready = 1'b1;
    wire setup = psel && !penable;
    wire wr_en = psel && penable && pwrite;
    reg mapped;
    reg [31:0] rd_mux;
    always @*
    begin
        mapped = 1'b1;
        case (paddr)
            `PID_CTRL_OFF: rd_mux = {23'h000000, output_polarity_select,
                1'b0, feedback_source_select, setpoint_source_select};
            `PID_MODE_OFF: rd_mux = {20'h00000, voltage_channel_select,
                secondary_freq_command_select, primary_freq_command_select};
            `PID_KEYPAD_OFF: rd_mux = {{16{keypad_setpoint_value[15]}},
                keypad_setpoint_value};
            `PID_KP_OFF: rd_mux = {16'h0000, proportional_gain_setting};
            `PID_TI_OFF: rd_mux = {16'h0000, integral_time_setting};
            `PID_TD_OFF: rd_mux = {16'h0000, derivative_time_setting};
            `PID_TS_OFF: rd_mux = {16'h0000, sample_period_setting};
            `PID_DEADBAND_OFF: rd_mux = {16'h0000, error_deadband_limit};
            `PID_UPPER_OFF: rd_mux = {{16{output_upper_limit[15]}},
                output_upper_limit};
            `PID_LOWER_OFF: rd_mux = {{16{output_lower_limit[15]}},
                output_lower_limit};
            `PID_STATUS_OFF: rd_mux = {reference_out, 12'h000, in_band_q,
                div_busy, ~state_q[0], pid_active};
            default:
            begin
                rd_mux = 32'h00000000;
                mapped = 1'b0;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= !mapped || (pwrite && paddr == `PID_STATUS_OFF);
        end
    end

    // register writes, clipped to their setting ranges
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            setpoint_source_select <= 4'h0;
            feedback_source_select <= 3'h0;
            output_polarity_select <= 1'b0;
            primary_freq_command_select <= 4'h0;
            secondary_freq_command_select <= 4'h0;
            voltage_channel_select <= 4'h0;
            keypad_setpoint_value <= `PID_KEYPAD_RST;
            proportional_gain_setting <= `PID_KP_RST;
            integral_time_setting <= `PID_TI_RST;
            derivative_time_setting <= `PID_TD_RST;
            sample_period_setting <= `PID_TS_RST;
            error_deadband_limit <= `PID_DEADBAND_RST;
            output_upper_limit <= `PID_UPPER_RST;
            output_lower_limit <= `PID_LOWER_RST;
        end
        else if (wr_en)
        begin
            case (paddr)
                `PID_CTRL_OFF:
                begin
                    setpoint_source_select <= pwdata[`PID_CTRL_SRC_LSB+:4];
                    feedback_source_select <= pwdata[`PID_CTRL_FB_LSB+:3];
                    output_polarity_select <= pwdata[`PID_CTRL_POL_BIT];
                end
                `PID_MODE_OFF:
                begin
                    primary_freq_command_select <=
                        pwdata[`PID_MODE_PRI_LSB+:4];
                    secondary_freq_command_select <=
                        pwdata[`PID_MODE_SEC_LSB+:4];
                    voltage_channel_select <= pwdata[`PID_MODE_VOLT_LSB+:4];
                end
                `PID_KEYPAD_OFF: keypad_setpoint_value <=
                    clip({{10{pwdata[31]}}, pwdata}, full_neg, full_pos);
                `PID_KP_OFF: proportional_gain_setting <=
                    umax(pwdata, `PID_KP_MAX);
                `PID_TI_OFF: integral_time_setting <=
                    umax(pwdata, `PID_TI_MAX);
                `PID_TD_OFF: derivative_time_setting <=
                    umax(pwdata, `PID_TD_MAX);
                // a zero period would stall sampling, so it reads as 1 ms
                `PID_TS_OFF: sample_period_setting <=
                    (pwdata == 32'h00000000) ? 16'h0001 :
                    umax(pwdata, `PID_TS_MAX);
                `PID_DEADBAND_OFF: error_deadband_limit <=
                    umax(pwdata, `PID_FULL_SCALE);
                `PID_UPPER_OFF: output_upper_limit <=
                    clip({{10{pwdata[31]}}, pwdata}, output_lower_limit,
                    full_pos);
                `PID_LOWER_OFF: output_lower_limit <=
                    clip({{10{pwdata[31]}}, pwdata}, full_neg,
                    output_upper_limit);
                default:
                    keypad_setpoint_value <= keypad_setpoint_value;
            endcase
        end
    end
endmodule // pid_regulator

/* File: pid_regulator_assertions.sv */
// concurrent checks on the regulator's bus and reference ports
// assumes one pclk domain; bound into every pid_regulator instance
`timescale 1ns/1ps
module pid_checker #(
    parameter MS_CYCLES = 10
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire pid_active,
    input wire ref_is_voltage,
    input wire signed [15:0] reference_out,
    input wire reference_strobe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a completed write to the mode register
    sequence mode_wr;
        psel && penable && pwrite && paddr == 8'h04;
    endsequence
    // quiet gap after an update; the shortest period is one ms
    sequence quiet_gap;
        ##1 (!reference_strobe) [*8];
    endsequence
    freq_mode_a: assert property (mode_wr ##0 pwdata[3:0] == 4'h7
        |=> pid_active) else $error("freq code 7 not active");
    volt_mode_a: assert property (mode_wr ##0 pwdata[11:8] == 4'h6
        |=> ref_is_voltage && pid_active) else $error("volt code 6 lost");
    idle_mode_a: assert property (mode_wr ##0 pwdata[11:0] == 12'h000
        |=> !pid_active) else $error("active with no pid code");
    update_gap_a: assert property (reference_strobe |-> quiet_gap)
        else $error("updates closer than one period");
    ref_hold_a: assert property ($changed(reference_out)
        |-> reference_strobe) else $error("reference moved unstrobed");
    bus_ready_a: assert property (psel |-> pready)
        else $error("slave not ready");
    unmapped_err_a: assert property (psel && penable && paddr > 8'h28
        |-> pslverr) else $error("unmapped access not refused");
    status_ro_a: assert property (psel && penable && pwrite
        && paddr == 8'h28 |-> pslverr) else $error("status write taken");
endmodule // pid_checker

bind pid_regulator pid_checker #(.MS_CYCLES(MS_CYCLES)) pid_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .pid_active(pid_active),
    .ref_is_voltage(ref_is_voltage), .reference_out(reference_out),
    .reference_strobe(reference_strobe)
);

/* File: chan_model.sv */
// channel sources feeding the regulator: analog, pulse and bus values
// assumes the bench sets levels between regulator samples
`timescale 1ns/1ps
module chan_model (
    output logic signed [15:0] ch [8]
);
    // static levels in 0.1 % steps inside the relative span
    initial ch = '{default: 16'sh0000};
    // a channel is set whole; sp and fb stay on distinct channels
    task automatic set_chan(input int i, input logic signed [15:0] v);
        ch[i] <= v;
    endtask
endmodule // chan_model

/* File: pid_regulator_tb.sv */
// self-checking bench for the regulator over apb
// assumes the channel model and the bound checker are compiled alongside
`timescale 1ns/1ps
module pid_regulator_tb;
    logic pclk, presetn, psel, penable, pwrite, err, got;
    logic [7:0] paddr;
    logic [31:0] pwdata, rdv;
    logic signed [15:0] r1, r2;
    wire [31:0] prdata;
    wire pready, pslverr, pid_active, ref_is_voltage, reference_strobe;
    wire signed [15:0] reference_out;
    wire signed [15:0] ch [8];
    int miscompares, n_compared, cyc, f, sp;
    logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14,
        8'h18, 8'h1C, 8'h20};
    logic [15:0] rv [9] = '{16'h0000, 16'h0000, 16'h0000, 16'h0064,
        16'h0064, 16'h0000, 16'h0064, 16'h0000, 16'h03E8};

    chan_model chan_model_inst (.ch(ch));
    pid_regulator #(.MS_CYCLES(10)) pid_regulator_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .analog_input_one(ch[0]), .analog_input_two(ch[1]),
        .analog_input_three(ch[2]), .high_speed_pulse_input(ch[3]),
        .multi_step_speed_value(ch[4]), .modbus_value(ch[5]),
        .fieldbus_value(ch[6]), .ethernet_value(ch[7]),
        .pid_active(pid_active), .ref_is_voltage(ref_is_voltage),
        .reference_out(reference_out), .reference_strobe(reference_strobe)
    );

    task test_done;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // setup, then access held until pready is seen high at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdv = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // strobe is a one-cycle pulse, so poll it at the settled half
    task wait_strobe(input int n);
        got = 1'b0;
        repeat (n)
        begin
            @(negedge pclk);
            if (reference_strobe === 1'b1)
            begin
                got = 1'b1;
                return;
            end
        end
    endtask
    // second update is surely taken after the new control word
    task run(input logic [31:0] ctrl, input logic signed [15:0] exp);
        apb(1'b1, 8'h00, ctrl);
        wait_strobe(300);
        wait_strobe(300);
        check(got, 1'b1);
        check(reference_out, exp);
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    // hang guard; the full sequence needs under 12000 cycles
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            test_done;
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
        for (int i = 0; i < 8; i++)
            chan_model_inst.set_chan(i, 16'(50 * i + 50));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            apb(1'b0, ra[i], 32'h0);
            check(rdv[15:0], rv[i]);
        end
        apb(1'b0, 8'h40, 32'h0);
        check(err, 1'b1);
        apb(1'b1, 8'h28, 32'h0);
        check(err, 1'b1);
        apb(1'b1, 8'h0C, 32'h2710);
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h18, 32'h14);
        apb(1'b1, 8'h08, 32'h1C2);
        apb(1'b1, 8'h04, 32'h7);
        @(negedge pclk);
        check(pid_active, 1'b1);
        // feedback on the first analog input, or the second against it
        for (int s = 0; s < 9; s++)
        begin
            f = (s == 1) ? 1 : 0;
            sp = (s == 0) ? 450 : 50 * s;
            run(32'(f * 16 + s), 16'(sp - 50 * (f + 1)));
        end
        // remaining feedback codes against the keypad; code 7 reads zero
        for (int c = 2; c < 8; c++)
        begin
            f = (c == 7) ? 0 : 50 * (c + 1 + ((c > 3) ? 1 : 0));
            run(32'(c * 16), 16'(450 - f));
        end
        run(32'h9, 16'hFFCE);
        run(32'h100, 16'hFE70);
        apb(1'b1, 8'h24, 32'hFFFFFF38);
        run(32'h100, 16'hFF38);
        apb(1'b1, 8'h20, 32'h12C);
        run(32'h0, 16'h012C);
        apb(1'b1, 8'h1C, 32'h1F4);
        wait_strobe(450);
        check(got, 1'b0);
        check(reference_out, 16'h012C);
        apb(1'b1, 8'h04, 32'h600);
        @(negedge pclk);
        check(ref_is_voltage, 1'b1);
        apb(1'b1, 8'h1C, 32'h0);
        apb(1'b1, 8'h0C, 32'h0);
        apb(1'b1, 8'h10, 32'h64);
        wait_strobe(300);
        wait_strobe(300);
        r1 = reference_out;
        wait_strobe(300);
        r2 = reference_out;
        check(r2 - r1, 32'h8);
        // derivative only: a 10-count feedback rise gives -10 at Td=Ts
        apb(1'b1, 8'h10, 32'h0);
        apb(1'b1, 8'h14, 32'h2);
        wait_strobe(300);
        @(posedge pclk);
        chan_model_inst.set_chan(0, 16'sh003C);
        wait_strobe(300);
        check(reference_out, 16'shFFF6);
        apb(1'b1, 8'h04, 32'h0);
        @(negedge pclk);
        check(pid_active, 1'b0);
        apb(1'b1, 8'h04, 32'h70);
        @(negedge pclk);
        check(pid_active, 1'b1);
        test_done;
    end
endmodule // pid_regulator_tb
